// ==== design/sps_cfg.svh ====
/*
  Reset values and default sizes for the shared serial port pin block.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// default counter widths
`define SPS_DIV_W    8
`define SPS_LEN_W    5
`define SPS_WORDS_W  4

// reset values
`define SPS_BIT_RST  1'b0
`define SPS_SS_RST   1'b1
`define SPS_SYNC_RST 2'h0

`endif

// ==== design/sps_pkg.sv ====
/*
  Types for the shared serial port pin block.
  Assumes sps_cfg.svh is on the include path.
*/
package sps_pkg;
  `include "sps_cfg.svh"

  // function connected to a shared pin
  typedef enum logic [1:0] {
    SPS_FN_GPIO,
    SPS_FN_SPI,
    SPS_FN_SSI
  } sps_func_type;

  // drive toward one pad
  typedef struct packed {
    logic dout;
    logic oe;
  } sps_pad_type;
endpackage

// ==== design/sps_top.sv ====
/*
  Pin sharing for two serial port pins: pad A (SPI master-in, general I/O
  bit zero, receive bit clock) and pad B (SPI master-out, general I/O bit
  one, receive frame sync). Includes launch timing, receive clock and
  frame sync generation and a receive-clock link domain.
  Assumes: the testbench joins pad wires from _O/_OE_O/_I; SRX_CLK_I is the
  level seen on pad A; sync serial sizes are static while SSI_EN_I is high.
*/
// Overview of operation
// R1: as SPI master the master-in pin is input; as slave it is driven.
// R2: an unselected slave keeps its master-in output in high impedance.
// R3: master-out pin is driven as master and sampled as slave.
// R4: master-out data changes half a clock before the latching edge.
// R5: each pin has its own direction in general I/O mode.
// R6: receive clock pin is bidirectional, continuous or gated.
// R7: frame sync delimits frames; internally from frame and word dividers.
// R8: a pin falls back to general I/O when sync serial is unused.
// R9: select input picks a slave, or flags a rival master in master role.
// R10: exactly one function drives each pad, chosen by configuration.
`timescale 1ns/1ps
`default_nettype none
`include "sps_cfg.svh"

module sps_top
  import sps_pkg::*;
#(
  parameter int DIV_W   = `SPS_DIV_W,
  parameter int LEN_W   = `SPS_LEN_W,
  parameter int WORDS_W = `SPS_WORDS_W
) (
  input  wire logic               CLK_I,
  input  wire logic               RSTN_I,
  input  wire logic               CE_I,
  input  wire logic               SRX_CLK_I,
  input  wire logic               PAD_A_I,
  output logic                    PAD_A_O,
  output logic                    PAD_A_OE_O,
  input  wire logic               PAD_B_I,
  output logic                    PAD_B_O,
  output logic                    PAD_B_OE_O,
  input  wire logic               SS_N_I,
  input  wire sps_func_type       FUNC_A_I,
  input  wire sps_func_type       FUNC_B_I,
  input  wire logic               SSI_EN_I,
  input  wire logic               SPI_MASTER_I,
  input  wire logic               SPI_SCK_I,
  input  wire logic               SPI_LOAD_I,
  input  wire logic               SPI_TX_BIT_I,
  output logic                    SPI_RX_BIT_O,
  output logic                    SPI_SELECTED_O,
  output logic                    SPI_MODE_FAULT_O,
  input  wire logic [1:0]         GPIO_DIR_I,
  input  wire logic [1:0]         GPIO_OUT_I,
  output logic      [1:0]         GPIO_IN_O,
  input  wire logic               SSI_CLK_INT_I,
  input  wire logic               SSI_FS_INT_I,
  input  wire logic               SSI_CLK_GATED_I,
  input  wire logic               SSI_RUN_I,
  input  wire logic [DIV_W-1:0]   BCLK_DIV_I,
  input  wire logic [LEN_W-1:0]   WORD_LEN_I,
  input  wire logic [WORDS_W-1:0] FRAME_WORDS_I,
  output logic                    SSI_WORD_O,
  output logic                    SSI_FRAME_O
);

  if (DIV_W < 1 || LEN_W < 2 || WORDS_W < 1) begin : g_bad_size
    $error("sps_top: counter widths too small");
  end

  // effective function per pad
  sps_func_type eff_a;
  sps_func_type eff_b;
  // R8: fallback to general I/O
  assign eff_a = (FUNC_A_I == SPS_FN_SSI && !SSI_EN_I) ? SPS_FN_GPIO : FUNC_A_I;
  assign eff_b = (FUNC_B_I == SPS_FN_SSI && !SSI_EN_I) ? SPS_FN_GPIO : FUNC_B_I;

  // pin synchronisers: bit0 pad A, bit1 pad B, bit2 select
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s1_q <= {`SPS_SS_RST, `SPS_SYNC_RST};
      s2_q <= {`SPS_SS_RST, `SPS_SYNC_RST};
    end else if (CE_I) begin
      s1_q <= {SS_N_I, PAD_B_I, PAD_A_I};
      s2_q <= s1_q;
    end
  end

  wire pad_a_s = s2_q[0];
  wire pad_b_s = s2_q[1];
  wire ss_n_s  = s2_q[2];

  // SPI launch and receive
  logic sck_q;
  logic launch_q;
  logic rx_q;
  logic sel_q;
  logic fault_q;
  wire  sck_fall  = sck_q && !SPI_SCK_I;
  wire  launch_en = sck_fall || SPI_LOAD_I;
  wire  spi_any   = (eff_a == SPS_FN_SPI) || (eff_b == SPS_FN_SPI);
  wire  rx_src    = SPI_MASTER_I ? pad_a_s : pad_b_s;
  wire  rival_d   = spi_any && SPI_MASTER_I && !ss_n_s;
  wire  slave_sel = !SPI_MASTER_I && !ss_n_s;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sck_q    <= `SPS_BIT_RST;
      launch_q <= `SPS_BIT_RST;
      rx_q     <= `SPS_BIT_RST;
      sel_q    <= `SPS_BIT_RST;
      fault_q  <= `SPS_BIT_RST;
    end else if (CE_I) begin
      sck_q <= SPI_SCK_I;
      // R4: launch on trailing edge
      if (launch_en) begin
        launch_q <= SPI_TX_BIT_I;
      end
      rx_q <= rx_src;
      // R9: select or arbitration
      sel_q   <= slave_sel;
      fault_q <= rival_d;
    end
  end

  assign SPI_RX_BIT_O     = rx_q;
  assign SPI_SELECTED_O   = sel_q;
  assign SPI_MODE_FAULT_O = fault_q;

  // internal receive bit clock and frame sync
  logic [DIV_W-1:0]   div_q;
  logic [LEN_W-1:0]   bit_q;
  logic [WORDS_W-1:0] word_q;
  logic               bclk_q;
  logic               fs_q;
  wire  ssi_on     = (eff_a == SPS_FN_SSI) && SSI_CLK_INT_I;
  wire  gate_off   = !ssi_on || (SSI_CLK_GATED_I && !SSI_RUN_I);
  wire  div_end    = (div_q == BCLK_DIV_I);
  wire  tick       = div_end && bclk_q;
  wire  word_end   = (bit_q == WORD_LEN_I);
  wire  frame_end  = word_end && (word_q == FRAME_WORDS_I);
  wire  int_word   = tick && word_end;
  wire  int_frame  = tick && frame_end;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      div_q  <= '0;
      bclk_q <= `SPS_BIT_RST;
      bit_q  <= '0;
      word_q <= '0;
      fs_q   <= `SPS_BIT_RST;
    end else if (CE_I) begin
      // R6: gated clock parks low
      if (gate_off) begin
        div_q  <= '0;
        bclk_q <= `SPS_BIT_RST;
        bit_q  <= '0;
        word_q <= '0;
        fs_q   <= `SPS_BIT_RST;
      end else begin
        div_q <= div_end ? '0 : DIV_W'(div_q + 1'b1);
        if (div_end) begin
          bclk_q <= !bclk_q;
        end
        // R7: word and frame dividers
        if (tick) begin
          bit_q <= word_end ? '0 : LEN_W'(bit_q + 1'b1);
          if (word_end) begin
            word_q <= frame_end ? '0 : WORDS_W'(word_q + 1'b1);
          end
          fs_q <= frame_end;
        end
      end
    end
  end

  // link domain: external frame sync, latched on receive clock rise
  logic [LEN_W-1:0] l_bit_q;
  logic             l_wtog_q;
  logic             l_ftog_q;
  always_ff @(posedge SRX_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      l_bit_q  <= '0;
      l_wtog_q <= `SPS_BIT_RST;
      l_ftog_q <= `SPS_BIT_RST;
    end else if (PAD_B_I) begin
      l_bit_q  <= LEN_W'(1);
      l_ftog_q <= !l_ftog_q;
    end else if (l_bit_q == WORD_LEN_I) begin
      l_bit_q  <= '0;
      l_wtog_q <= !l_wtog_q;
    end else begin
      l_bit_q <= LEN_W'(l_bit_q + 1'b1);
    end
  end

  // toggle crossing of word and frame events
  logic [1:0] t1_q;
  logic [1:0] t2_q;
  logic [1:0] t3_q;
  logic       word_o_q;
  logic       frame_o_q;
  wire  [1:0] ext_ev  = t2_q ^ t3_q;
  wire        fs_own  = ssi_on && SSI_FS_INT_I;
  wire        ssi_rx  = (eff_a == SPS_FN_SSI) && (eff_b == SPS_FN_SSI);
  wire        word_d  = ssi_rx && (fs_own ? int_word : ext_ev[0]);
  wire        frame_d = ssi_rx && (fs_own ? int_frame : ext_ev[1]);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      t1_q      <= `SPS_SYNC_RST;
      t2_q      <= `SPS_SYNC_RST;
      t3_q      <= `SPS_SYNC_RST;
      word_o_q  <= `SPS_BIT_RST;
      frame_o_q <= `SPS_BIT_RST;
    end else if (CE_I) begin
      t1_q      <= {l_ftog_q, l_wtog_q};
      t2_q      <= t1_q;
      t3_q      <= t2_q;
      word_o_q  <= word_d;
      frame_o_q <= frame_d;
    end
  end

  assign SSI_WORD_O  = word_o_q;
  assign SSI_FRAME_O = frame_o_q;

  // R10: one function per pad
  sps_pad_type pad_a;
  sps_pad_type pad_b;
  // R1: master-in direction by role
  // R2: unselected slave floats
  assign pad_a = (eff_a == SPS_FN_SPI) ? sps_pad_type'{dout: launch_q, oe: slave_sel} :
                 (eff_a == SPS_FN_SSI) ? sps_pad_type'{dout: bclk_q, oe: SSI_CLK_INT_I} :
                 sps_pad_type'{dout: GPIO_OUT_I[0], oe: GPIO_DIR_I[0]};
  // R3: master-out direction by role
  assign pad_b = (eff_b == SPS_FN_SPI) ? sps_pad_type'{dout: launch_q, oe: SPI_MASTER_I} :
                 (eff_b == SPS_FN_SSI) ? sps_pad_type'{dout: fs_q, oe: fs_own} :
                 sps_pad_type'{dout: GPIO_OUT_I[1], oe: GPIO_DIR_I[1]};

  assign PAD_A_O    = pad_a.dout;
  assign PAD_A_OE_O = pad_a.oe;
  assign PAD_B_O    = pad_b.dout;
  assign PAD_B_OE_O = pad_b.oe;

  // R5: per-pin general input
  for (genvar i = 0; i < 2; i++) begin : g_gpio
    assign GPIO_IN_O[i] = s2_q[i];
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  AST_MASTER_IN: assert property ( // R1
    (eff_a == SPS_FN_SPI && SPI_MASTER_I) |-> !PAD_A_OE_O)
    else $error("master-in pad driven in master role");

  AST_UNSEL_HIZ: assert property ( // R2
    (eff_a == SPS_FN_SPI) |-> (PAD_A_OE_O == (!SPI_MASTER_I && !ss_n_s)))
    else $error("slave output enable wrong for select state");

  AST_MASTER_OUT: assert property ( // R3
    (eff_b == SPS_FN_SPI) |-> (PAD_B_OE_O == SPI_MASTER_I && PAD_B_O == launch_q))
    else $error("master-out pad direction wrong");

  AST_LAUNCH_EDGE: assert property ( // R4
    $changed(launch_q) |-> ($past(CE_I) && $past(launch_en)))
    else $error("launch data changed away from trailing edge");

  AST_GPIO_DIR: assert property ( // R5
    (eff_b == SPS_FN_GPIO) |-> (PAD_B_OE_O == GPIO_DIR_I[1] && PAD_B_O == GPIO_OUT_I[1]))
    else $error("general pin B not following its direction");

  AST_CLK_GATE: assert property ( // R6
    (CE_I && gate_off) |=> !bclk_q && div_q == '0)
    else $error("receive bit clock runs while gated");

  AST_FS_FRAME: assert property ( // R7
    $rose(fs_q) |-> (bit_q == '0 && word_q == '0 && $past(frame_end)))
    else $error("frame sync outside frame start");

  AST_FALLBACK: assert property ( // R8
    (FUNC_A_I == SPS_FN_SSI && !SSI_EN_I) |-> (PAD_A_OE_O == GPIO_DIR_I[0]))
    else $error("pad A did not fall back to general I/O");

  AST_RIVAL: assert property ( // R9
    (CE_I && rival_d) |=> SPI_MODE_FAULT_O ##0 !SPI_SELECTED_O)
    else $error("rival master not flagged");

  AST_ONE_FUNC: assert property ( // R10
    (eff_a == SPS_FN_SSI) |-> (PAD_A_O == bclk_q && PAD_A_OE_O == SSI_CLK_INT_I))
    else $error("pad A not carrying the receive clock");

  COV_SLAVE_SEL: cover property (eff_a == SPS_FN_SPI && PAD_A_OE_O);
  COV_FAULT: cover property ($rose(SPI_MODE_FAULT_O));
  COV_INT_FRAME: cover property (fs_own && SSI_FRAME_O);
  COV_EXT_WORD: cover property (!fs_own && SSI_WORD_O);

endmodule
`default_nettype wire

// ==== sim/sps_peer.sv ====
/*
  Far-side peer of the shared pins: SPI partner lines, external receive
  bit clock and frame sync.
  Assumes the bench resolves the pad wires and supplies the link clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sps_peer #(
  parameter int FR_BITS = 4
) (
  input  wire logic lclk_i,
  input  wire logic ext_i,
  input  wire logic run_i,
  input  wire logic a_en_i,
  input  wire logic a_i,
  input  wire logic b_en_i,
  input  wire logic b_i,
  output logic      a_o,
  output logic      a_oe_o,
  output logic      b_o,
  output logic      b_oe_o
);
  logic       run_q = 1'h0;
  logic [3:0] cnt_q = 4'h0;

  // clock gated on the low phase, still between frames
  always @(negedge lclk_i) begin
    run_q <= run_i;
    cnt_q <= (!run_q || cnt_q == 4'(FR_BITS - 1)) ? 4'h0 : cnt_q + 4'h1;
  end

  // sync high on bit zero; data lines released unless enabled
  assign a_oe_o = ext_i | a_en_i;
  assign a_o    = ext_i ? (run_q & lclk_i) : a_i;
  assign b_oe_o = ext_i | b_en_i;
  assign b_o    = ext_i ? (run_q && cnt_q == 4'h0) : b_i;
endmodule

`default_nettype wire

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the shared serial port pin block.
  Assumes sps_pkg, sps_top and sps_peer are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import sps_pkg::*;
;
  logic clk = '0, lclk = '0, rstn = '0, flt = '0, a_prev = '0;
  logic ss_n = '1, ssi_en = '0, mst = '0, sck = '0, load = '0, tx = '0;
  logic cint = '0, fint = '0, gated = '0, run = '0, prun = '0, pext = '0;
  logic pa_en = '0, pa = '0, pb_en = '0, pb = '0, ce = '1;
  logic [1:0] gdir = '0, gout = '0;
  logic [7:0] div = '0;
  logic [4:0] wlen = '0;
  logic [3:0] fw = '0;
  sps_func_type fa = SPS_FN_GPIO, fb = SPS_FN_GPIO;
  wire logic a_o, a_oe, b_o, b_oe, pa_o, pa_oe, pb_o, pb_oe, rx, sel, flt_m, wd, fr;
  wire logic [1:0] gin;
  wire logic pad_a = a_oe ? a_o : pa_oe ? pa_o : flt;
  wire logic pad_b = b_oe ? b_o : pb_oe ? pb_o : flt;
  int n_mismatch = 0, num_checks = 0, cycles = 0, n_wd = 0, n_fr = 0, n_bc = 0;

  always #2.5 clk = ~clk;
  initial begin
    #7;
    forever #24 lclk = ~lclk;
  end

  sps_top dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .SRX_CLK_I(pad_a),
    .PAD_A_I(pad_a), .PAD_A_O(a_o), .PAD_A_OE_O(a_oe), .PAD_B_I(pad_b),
    .PAD_B_O(b_o), .PAD_B_OE_O(b_oe), .SS_N_I(ss_n), .FUNC_A_I(fa), .FUNC_B_I(fb),
    .SSI_EN_I(ssi_en), .SPI_MASTER_I(mst), .SPI_SCK_I(sck), .SPI_LOAD_I(load),
    .SPI_TX_BIT_I(tx), .SPI_RX_BIT_O(rx), .SPI_SELECTED_O(sel),
    .SPI_MODE_FAULT_O(flt_m), .GPIO_DIR_I(gdir), .GPIO_OUT_I(gout), .GPIO_IN_O(gin),
    .SSI_CLK_INT_I(cint), .SSI_FS_INT_I(fint), .SSI_CLK_GATED_I(gated),
    .SSI_RUN_I(run), .BCLK_DIV_I(div), .WORD_LEN_I(wlen), .FRAME_WORDS_I(fw),
    .SSI_WORD_O(wd), .SSI_FRAME_O(fr));

  sps_peer peer (.lclk_i(lclk), .ext_i(pext), .run_i(prun), .a_en_i(pa_en), .a_i(pa),
    .b_en_i(pb_en), .b_i(pb), .a_o(pa_o), .a_oe_o(pa_oe), .b_o(pb_o), .b_oe_o(pb_oe));

  // released pads show a changing level; event counters; hang guard
  always @(posedge clk) begin
    flt <= ~flt;
    a_prev <= a_o;
    if (a_o === 1'h1 && a_prev === 1'h0) n_bc++;
    if (wd === 1'h1) n_wd++;
    if (fr === 1'h1) n_fr++;
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0h got %0h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_gpio;
    @(posedge clk);
    fb <= SPS_FN_SSI;
    gdir <= 2'h1;
    gout <= 2'h1;
    pb_en <= '1;
    cyc(4);
    chk("a oe", a_oe, 8'h01);
    chk("a out", a_o, 8'h01);
    chk("b oe", b_oe, 8'h00);
    chk("gpio in", gin, 8'h01);
    @(posedge clk);
    gdir <= 2'h2;
    gout <= 2'h2;
    pb_en <= '0;
    pa_en <= '1;
    cyc(4);
    chk("oe swap", {b_oe, a_oe}, 8'h02);
    chk("gpio in 2", gin, 8'h02);
    @(posedge clk);
    ce <= '0;
    pa <= '1;
    cyc(4);
    chk("frozen in", gin, 8'h02);
    @(posedge clk);
    ce <= '1;
    cyc(4);
    chk("thawed in", gin, 8'h03);
    $display("test gpio done");
  endtask

  task automatic t_spi_master;
    @(posedge clk);
    fa <= SPS_FN_SPI;
    fb <= SPS_FN_SPI;
    mst <= '1;
    pa <= '1;
    cyc(4);
    chk("m a oe", a_oe, 8'h00);
    chk("m b oe", b_oe, 8'h01);
    chk("m rx", rx, 8'h01);
    @(posedge clk);
    load <= '1;
    tx <= '1;
    @(posedge clk);
    load <= '0;
    tx <= '0;
    sck <= '1;
    cyc(3);
    chk("held bit", b_o, 8'h01);
    @(posedge clk);
    sck <= '0;
    cyc(2);
    chk("next bit", b_o, 8'h00);
    @(posedge clk);
    ss_n <= '0;
    cyc(4);
    chk("mode fault", flt_m, 8'h01);
    $display("test spi master done");
  endtask

  task automatic t_spi_slave;
    @(posedge clk);
    mst <= '0;
    ss_n <= '1;
    pa_en <= '0;
    pb_en <= '1;
    pb <= '1;
    cyc(4);
    chk("s a oe off", a_oe, 8'h00);
    chk("s b oe", b_oe, 8'h00);
    chk("s rx", rx, 8'h01);
    chk("s unsel", sel, 8'h00);
    @(posedge clk);
    ss_n <= '0;
    cyc(4);
    chk("s a oe on", a_oe, 8'h01);
    chk("s sel", sel, 8'h01);
    @(posedge clk);
    load <= '1;
    tx <= '1;
    @(posedge clk);
    load <= '0;
    tx <= '0;
    cyc(1);
    chk("s miso", a_o, 8'h01);
    @(posedge clk);
    ss_n <= '1;
    cyc(4);
    chk("s a oe rel", a_oe, 8'h00);
    $display("test spi slave done");
  endtask

  task automatic t_ssi_int;
    @(posedge clk);
    fa <= SPS_FN_SSI;
    fb <= SPS_FN_SSI;
    ssi_en <= '1;
    cint <= '1;
    fint <= '1;
    wlen <= 5'h01;
    fw <= 4'h1;
    pb_en <= '0;
    cyc(20);
    {n_wd, n_fr, n_bc} = '0;
    cyc(80);
    chk("i a oe", a_oe, 8'h01);
    chk("i b oe", b_oe, 8'h01);
    chk("bit clocks", 8'(n_bc), 8'h28);
    chk("words", 8'(n_wd), 8'h14);
    chk("frames", 8'(n_fr), 8'h0A);
    @(posedge clk);
    gated <= '1;
    cyc(4);
    {n_wd, n_bc} = '0;
    cyc(40);
    chk("gated clocks", 8'(n_bc), 8'h00);
    chk("gated words", 8'(n_wd), 8'h00);
    @(posedge clk);
    run <= '1;
    cyc(4);
    n_bc = 0;
    cyc(40);
    chk("run clocks", 8'(n_bc), 8'h14);
    $display("test ssi internal done");
  endtask

  task automatic t_ssi_ext;
    @(posedge clk);
    cint <= '0;
    fint <= '0;
    gated <= '0;
    pext <= '1;
    cyc(8);
    chk("e a oe", a_oe, 8'h00);
    chk("e b oe", b_oe, 8'h00);
    n_fr = 0;
    n_wd = 0;
    @(posedge lclk) prun <= '1;
    repeat (16) @(posedge lclk);
    prun <= '0;
    cyc(20);
    chk("ext frames", 8'(n_fr), 8'h04);
    chk("ext words", 8'(n_wd), 8'h08);
    $display("test ssi external done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rstn <= '1;
    cyc(4);
    t_gpio();
    t_spi_master();
    t_spi_slave();
    t_ssi_int();
    t_ssi_ext();
    wrap_up();
  end
endmodule

`default_nettype wire
